// *** design/pcs_clock_select.sv ***
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Function
// - PLL selection always forces system divider
// - Divider enable routes clock through divider
// - Override selects secondary divisor field
// - PWM enable selects divided PWM clock
// - PWM codes two to sixty-four, saturating
// - PWM edges align with system edges
// - Reserved bits read zero, ignore writes
// - Power-down bit drives PLL directly
// - Gate bit blocks PLL clock output
// - PLL runs only with both cleared
// - Bypass or stopped PLL picks oscillator, else divided PLL
// - Verify bit enables PLL failure timer
// - Oscillator source field picks oscillator input
module pcs_clock_select
  import pcs_pkg::*;
#(
  parameter int VFY_TIMEOUT = PCS_VFY_TIMEOUT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // PLL control
  output logic pll_power_down,
  output logic pll_output_gate,
  input wire logic pll_clk_tick,
  // Clock tree settings
  output logic [1:0] osc_source_select,
  output logic sys_use_pll,
  output logic sys_use_divider,
  output logic [3:0] sys_divisor_eff,
  output logic [3:0] xtal_value,
  output logic pwm_clk_enable,
  output logic pll_fail_irq
);
  typedef enum logic [1:0] {PCS_SEL_OSC, PCS_SEL_HOLD, PCS_SEL_PLL} pcs_sel_type;

  logic [31:0] run_cfg_reg;
  logic [31:0] sec_cfg_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic wr_fire;
  logic [31:0] strb_mask;
  logic [31:0] rd_value;
  logic rd_ok;
  logic pll_running;
  logic want_pll;
  logic vfy_clear;
  pcs_sel_type sel_reg;
  logic [$clog2(VFY_TIMEOUT+1)-1:0] vfy_count_reg;
  logic pll_live_reg;
  logic pwm_tick;

  // ==========================================
  // Write channel capture
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      w_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end
  always_comb begin
    strb_mask = '0;
    for (int b = 0; b < 4; b++) begin
      strb_mask[b*8 +: 8] = {8{wstrb_reg[b]}};
    end
  end

  // ==========================================
  // Write response
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PCS_AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_reg == PCS_RUN_CFG_ADDR || awaddr_reg == PCS_SEC_CFG_ADDR ||
                      awaddr_reg == PCS_VFY_CLR_ADDR) ? PCS_AXI_OKAY : PCS_AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      run_cfg_reg <= PCS_RUN_RESET;
    end else if (wr_fire && awaddr_reg == PCS_RUN_CFG_ADDR) begin
      // Reserved bits never stored
      run_cfg_reg <= (run_cfg_reg & ~(strb_mask & PCS_RUN_WMASK)) |
                     (wdata_reg & strb_mask & PCS_RUN_WMASK);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sec_cfg_reg <= PCS_SEC_RESET;
    end else if (wr_fire && awaddr_reg == PCS_SEC_CFG_ADDR) begin
      sec_cfg_reg <= (sec_cfg_reg & ~(strb_mask & PCS_SEC_WMASK)) |
                     (wdata_reg & strb_mask & PCS_SEC_WMASK);
    end
  end
  assign vfy_clear = wr_fire && awaddr_reg == PCS_VFY_CLR_ADDR && wstrb_reg[0] &&
                     wdata_reg[PCS_ST_FAIL_BIT];

  // ==========================================
  // Read channel
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      PCS_RUN_CFG_ADDR: rd_value = run_cfg_reg;
      PCS_SEC_CFG_ADDR: rd_value = sec_cfg_reg;
      PCS_STATUS_ADDR: rd_value = {29'h0, sel_reg == PCS_SEL_PLL, pll_live_reg, pll_fail_irq};
      PCS_VFY_CLR_ADDR: rd_value = 32'h0;
      default: begin
        rd_value = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PCS_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_ok ? PCS_AXI_OKAY : PCS_AXI_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================
  // PLL control
  assign pll_running = !run_cfg_reg[PCS_PLL_POWER_DOWN_BIT] && !run_cfg_reg[PCS_GATE_BIT];
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pll_power_down <= 1'b1;
      pll_output_gate <= 1'b1;
    end else begin
      pll_power_down <= run_cfg_reg[PCS_PLL_POWER_DOWN_BIT];
      pll_output_gate <= run_cfg_reg[PCS_GATE_BIT];
    end
  end

  // ==========================================
  // System clock source and divider
  assign want_pll = !run_cfg_reg[PCS_BYPASS_BIT] && pll_running;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sel_reg <= PCS_SEL_OSC;
    end else begin
      // Pass through a hold step so the divider is already forced on at changeover
      case (sel_reg)
        PCS_SEL_OSC: sel_reg <= want_pll ? PCS_SEL_HOLD : PCS_SEL_OSC;
        PCS_SEL_HOLD: sel_reg <= want_pll ? PCS_SEL_PLL : PCS_SEL_OSC;
        PCS_SEL_PLL: sel_reg <= want_pll ? PCS_SEL_PLL : PCS_SEL_HOLD;
        default: sel_reg <= PCS_SEL_OSC;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sys_use_pll <= 1'b0;
      sys_use_divider <= 1'b0;
      sys_divisor_eff <= PCS_RUN_RESET[PCS_SYS_DIV_LSB +: 4];
      osc_source_select <= PCS_OSC_MAIN;
      xtal_value <= PCS_RUN_RESET[PCS_XTAL_LSB +: 4];
    end else begin
      sys_use_pll <= sel_reg == PCS_SEL_PLL;
      sys_use_divider <= run_cfg_reg[PCS_SYS_DIV_EN_BIT] || sel_reg != PCS_SEL_OSC;
      sys_divisor_eff <= sec_cfg_reg[PCS_OVR_BIT] ? sec_cfg_reg[PCS_SEC_DIV_LSB +: 4] :
                         run_cfg_reg[PCS_SYS_DIV_LSB +: 4];
      osc_source_select <= run_cfg_reg[PCS_OSC_SRC_LSB +: 2];
      xtal_value <= run_cfg_reg[PCS_XTAL_LSB +: 4];
    end
  end

  // ==========================================
  // PWM clock
  pcs_pow2_div #(
    .STAGES(6)
  ) u_pwm_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .div_code(run_cfg_reg[PCS_PWM_DIV_LSB +: 3]),
    .div_tick(pwm_tick)
  );
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pwm_clk_enable <= 1'b1;
    end else begin
      pwm_clk_enable <= run_cfg_reg[PCS_PWM_DIV_EN_BIT] ? pwm_tick : 1'b1;
    end
  end

  // ==========================================
  // PLL verification timer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      vfy_count_reg <= '0;
      pll_live_reg <= 1'b0;
    end else if (!run_cfg_reg[PCS_VERIFY_BIT] || !pll_running || pll_clk_tick) begin
      vfy_count_reg <= '0;
      pll_live_reg <= pll_clk_tick;
    end else if (vfy_count_reg != ($bits(vfy_count_reg))'(VFY_TIMEOUT)) begin
      vfy_count_reg <= vfy_count_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pll_fail_irq <= 1'b0;
    end else if (run_cfg_reg[PCS_VERIFY_BIT] && pll_running && !pll_clk_tick &&
                 vfy_count_reg == ($bits(vfy_count_reg))'(VFY_TIMEOUT - 1)) begin
      pll_fail_irq <= 1'b1;
    end else if (vfy_clear || !run_cfg_reg[PCS_VERIFY_BIT]) begin
      pll_fail_irq <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** design/pcs_pkg.sv ***
`default_nettype none
package pcs_pkg;
  // ==========================================
  // Register map
  localparam logic [3:0] PCS_RUN_CFG_ADDR = 4'h0;
  localparam logic [3:0] PCS_SEC_CFG_ADDR = 4'h4;
  localparam logic [3:0] PCS_STATUS_ADDR = 4'h8;
  localparam logic [3:0] PCS_VFY_CLR_ADDR = 4'hC;
  // ==========================================
  // Run-mode register fields
  localparam int PCS_SYS_DIV_LSB = 23;
  localparam int PCS_SYS_DIV_EN_BIT = 22;
  localparam int PCS_PWM_DIV_EN_BIT = 20;
  localparam int PCS_PWM_DIV_LSB = 17;
  localparam int PCS_PLL_POWER_DOWN_BIT = 13;
  localparam int PCS_GATE_BIT = 12;
  localparam int PCS_BYPASS_BIT = 11;
  localparam int PCS_VERIFY_BIT = 10;
  localparam int PCS_XTAL_LSB = 6;
  localparam int PCS_OSC_SRC_LSB = 4;
  localparam logic [31:0] PCS_RUN_WMASK = 32'h07DE3FF0;
  localparam logic [31:0] PCS_RUN_RESET = 32'h078E3AC0;
  // ==========================================
  // Secondary register fields
  localparam int PCS_OVR_BIT = 31;
  localparam int PCS_SEC_DIV_LSB = 23;
  localparam logic [31:0] PCS_SEC_WMASK = 32'h87800000;
  localparam logic [31:0] PCS_SEC_RESET = 32'h07800000;
  // ==========================================
  // Status bits
  localparam int PCS_ST_FAIL_BIT = 0;
  localparam int PCS_ST_LIVE_BIT = 1;
  localparam int PCS_ST_SEL_BIT = 2;
  // ==========================================
  // Codes
  localparam logic [2:0] PCS_PWM_DIV_MAX = 3'h5;
  localparam logic [1:0] PCS_OSC_MAIN = 2'h0;
  localparam logic [1:0] PCS_OSC_INT = 2'h1;
  localparam logic [1:0] PCS_OSC_INT4 = 2'h2;
  localparam logic [1:0] PCS_AXI_OKAY = 2'h0;
  localparam logic [1:0] PCS_AXI_SLVERR = 2'h2;
  localparam int PCS_VFY_TIMEOUT = 64;
endpackage
`default_nettype wire

// *** design/pcs_pow2_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcs_pow2_div
  import pcs_pkg::*;
#(
  parameter int STAGES = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Ratio code
  input wire logic [2:0] div_code,
  // Divided enable
  output logic div_tick
);
  logic [STAGES-1:0] count_reg;
  logic [2:0] code;
  assign code = (div_code >= PCS_PWM_DIV_MAX) ? PCS_PWM_DIV_MAX : div_code;
  // Free counter; tick on rollover of selected power of two
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      div_tick <= 1'b0;
    end else begin
      div_tick <= ((count_reg & ((STAGES'(2) << code) - 1'b1)) == '0);
    end
  end
endmodule
`default_nettype wire

// *** dv/pcs_clock_select_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker
module pcs_clock_select_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock control
  input wire logic pll_power_down,
  input wire logic pll_output_gate,
  input wire logic sys_use_pll,
  input wire logic sys_use_divider,
  input wire logic pll_fail_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_pll_forces_div: assert property (
    sys_use_pll |-> sys_use_divider) else $error("PLL path without divider");
  chk_pll_needs_run: assert property (
    $rose(sys_use_pll) |-> !pll_power_down && !pll_output_gate)
    else $error("PLL selected while stopped");
  chk_switch_hold: assert property (
    $changed(sys_use_pll) |-> $past(sys_use_divider)) else $error("changeover skipped hold");
  chk_reset_off: assert property (
    $rose(reset_n) |-> pll_power_down && pll_output_gate) else $error("PLL not off after reset");
  chk_irq_needs_run: assert property (
    $rose(pll_fail_irq) |-> !$past(pll_power_down)) else $error("fail raised with PLL off");
endmodule
bind pcs_clock_select pcs_clock_select_sva u_sva (.*);
`default_nettype wire

// *** dv/pcs_clock_select_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcs_clock_select_tb_top;
  import pcs_pkg::*;
  logic clk_sys = 0, reset_n = 0, pll_clk_tick = 0, tick_on = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pll_power_down, pll_output_gate, sys_use_pll, sys_use_divider;
  logic pwm_clk_enable, pll_fail_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, osc_source_select, r, rr;
  logic [3:0] sys_divisor_eff, xtal_value;
  int n_errors = 0, check_count = 0, cyc = 0, n, stall = 0;
  pcs_clock_select #(.VFY_TIMEOUT(4)) dut (.*);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) pll_clk_tick <= tick_on & ~pll_clk_tick;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      close_out;
    end
  end
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // ==========================================
  // Bus master
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ha, hw, hb;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (stall == 0);
    hb = 0;
    while (!hb) begin
      @(negedge clk_sys);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid & s_axi_bready;
      rs = s_axi_bresp;
      @(posedge clk_sys);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
      else if (stall > 0) stall--;
      else s_axi_bready <= 1'b1;
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    logic ha, hr;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (stall == 0);
    hr = 0;
    while (!hr) begin
      @(negedge clk_sys);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid & s_axi_rready;
      v = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk_sys);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
      else if (stall > 0) stall--;
      else s_axi_rready <= 1'b1;
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    rd(4'h0, d);
    chk(d, 32'h078E3AC0);
    rd(4'h4, d);
    chk(d, 32'h07800000);
    chk({pll_power_down, pll_output_gate, sys_use_pll, pwm_clk_enable}, 4'hD);
    chk(osc_source_select, 2'h0);
    chk(xtal_value, 4'hB);
    chk(sys_divisor_eff, 4'hF);
  endtask
  task automatic t_fields;
    wr(4'h0, 32'hFFFFFFFF, r);
    rd(4'h0, d);
    chk(d & 32'h0021C000, 32'h0);
    chk(d, 32'h07DE3FF0);
    chk(xtal_value, 4'hF);
    chk(sys_use_divider, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, 32'h00003800 | (i << 4), r);
      step(2);
      chk(osc_source_select, i);
    end
    chk(sys_use_divider, 1'b0);
    wr(4'h8, 32'h0, r);
    chk(r, PCS_AXI_SLVERR);
    wr(4'h0, 32'h01803800, r);
    wr(4'h4, 32'h84800000, r);
    step(2);
    chk(sys_divisor_eff, 4'h9);
    wr(4'h4, 32'h04800000, r);
    step(2);
    chk(sys_divisor_eff, 4'h3);
    wr(4'h4, 32'hFFFFFFFF, r);
    stall = 4;
    rd(4'h4, d);
    chk(d, 32'h87800000);
    s_axi_wstrb <= 4'h8;
    stall = 4;
    wr(4'h4, 32'h0, r);
    chk(r, PCS_AXI_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(4'h4, d);
    chk(d, 32'h00800000);
    rd(4'h1, d);
    chk(rr, PCS_AXI_SLVERR);
  endtask
  task automatic t_pll;
    wr(4'h0, 32'h00003000, r);
    step(6);
    chk(sys_use_pll, 1'b0);
    wr(4'h0, 32'h00000000, r);
    step(6);
    chk({sys_use_pll, sys_use_divider}, 2'h3);
    chk({pll_power_down, pll_output_gate}, 2'h0);
    wr(4'h0, 32'h00001000, r);
    step(6);
    chk({sys_use_pll, pll_output_gate}, 2'h1);
    wr(4'h0, 32'h00000000, r);
    step(6);
    wr(4'h0, 32'h00002000, r);
    step(6);
    chk({sys_use_pll, pll_power_down}, 2'h1);
    wr(4'h0, 32'h00000000, r);
    step(6);
    wr(4'h0, 32'h00000800, r);
    step(6);
    chk(sys_use_pll, 1'b0);
  endtask
  task automatic t_verify;
    tick_on <= 1'b1;
    wr(4'h0, 32'h00000400, r);
    step(20);
    chk(pll_fail_irq, 1'b0);
    tick_on <= 1'b0;
    step(12);
    chk(pll_fail_irq, 1'b1);
    rd(4'h8, d);
    chk(d & 32'h5, 32'h5);
    tick_on <= 1'b1;
    wr(4'hC, 32'h1, r);
    step(2);
    chk(pll_fail_irq, 1'b0);
    rd(4'h8, d);
    chk(d & 32'h1, 32'h0);
    wr(4'h0, 32'h00000000, r);
    tick_on <= 1'b0;
    step(20);
    chk(pll_fail_irq, 1'b0);
  endtask
  task automatic t_pwm;
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, 32'h00100800 | (c << 17), r);
      repeat (2) do @(negedge clk_sys); while (!pwm_clk_enable);
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (!pwm_clk_enable);
      chk(n, 2 << (c > 5 ? 5 : c));
    end
    wr(4'h0, 32'h00000800, r);
    n = 0;
    repeat (80) @(negedge clk_sys) n += pwm_clk_enable;
    chk(n, 80);
  endtask
  initial begin
    step(6);
    reset_n <= 1'b1;
    step(2);
    t_reset;
    t_fields;
    t_pll;
    t_verify;
    t_pwm;
    close_out;
  end
endmodule
`default_nettype wire
